// ### bench/ecu_capture_pair_properties.sv
// Purpose: Port-level checks for the capture pair
// Assumes: Unit 0 control words change only through APB writes
// Notes: Capture latency of one or two cycles is tolerated
`timescale 1ns/10ps
module ecu_cp_checker (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [ecu_pkg::ECU_UNITS-1:0] capture_input_pin_in,
  input wire logic idle_in,
  input wire logic [ecu_pkg::ECU_UNITS-1:0] capture_irq_out
);
  import ecu_pkg::*;
  logic [15:0] ctl1_reg;
  logic [15:0] ctl2_reg;
  logic acc;
  logic bad;
  logic quiet;
  logic rise_cfg;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  // Access phase, address decode and unit 0 settings
  assign acc = psel_in && penable_in;
  assign bad = paddr_in[11:5] != 7'h00 || paddr_in[1:0] != 2'h0 ||
    paddr_in[3:2] == 2'h3;
  assign quiet = ctl1_reg[2:0] == ECU_M_OFF || ctl1_reg[2:0] == ECU_M_DIS;
  assign rise_cfg = ctl1_reg[2:0] == ECU_M_RISE && ctl1_reg[6:5] == 2'h0 &&
    !ctl2_reg[7] && ctl2_reg[4:0] == ECU_SRC_OFF && !idle_in;

  // Shadow copies of the unit 0 control words
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctl1_reg <= ECU_CTL1_RESET;
      ctl2_reg <= ECU_CTL2_RESET;
    end else if (acc && pwrite_in && paddr_in == ECU_OFS_CTL1) begin
      ctl1_reg <= pwdata_in[15:0] & ECU_CTL1_WMASK;
    end else if (acc && pwrite_in && paddr_in == ECU_OFS_CTL2) begin
      ctl2_reg <= pwdata_in[15:0] & ECU_CTL2_WMASK;
    end
  end

  sequence s_read;
    acc && !pwrite_in;
  endsequence
  // Pin low three cycles, then high two
  sequence s_clean_rise;
    !capture_input_pin_in[0] [*3] ##1 capture_input_pin_in[0] [*2];
  endsequence

  a_err_decode: assert property (acc |-> pslverr_out == bad)
    else $error("slave error does not follow address decode");
  a_unmapped_zero: assert property (s_read ##0 bad |->
    prdata_out == 0)
    else $error("unmapped read returned data");
  a_ctl1_spare: assert property ((s_read ##0
    paddr_in[3:0] == 4'h0 && !bad) |->
    prdata_out[31:14] == 18'h0 && prdata_out[9:7] == 3'h0)
    else $error("spare primary control bits read nonzero");
  a_ctl2_spare: assert property ((s_read ##0
    paddr_in[3:0] == 4'h4 && !bad) |->
    prdata_out[31:9] == 23'h0 && !prdata_out[5])
    else $error("spare secondary control bits read nonzero");
  a_irq_on_edge: assert property (capture_irq_out[0] |->
    $past(capture_input_pin_in[0]) != $past(capture_input_pin_in[0], 2) ||
    $past(capture_input_pin_in[0], 2) != $past(capture_input_pin_in[0], 3))
    else $error("interrupt without a pin transition");
  a_irq_needs_mode: assert property (quiet && $past(quiet) &&
    $past(quiet, 2) |-> !capture_irq_out[0])
    else $error("interrupt while capture is off");
  a_rise_irq: assert property (s_clean_rise ##0 rise_cfg |->
    ##[0:1] capture_irq_out[0])
    else $error("rising edge gave no interrupt");
  a_fall_quiet: assert property ((s_clean_rise ##0
    ctl1_reg[2:0] == ECU_M_FALL) |-> !capture_irq_out[0] ##1
    !capture_irq_out[0])
    else $error("rising edge interrupted in falling mode");
endmodule

bind ecu_capture_pair ecu_cp_checker ecu_cp_checker_inst (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .capture_input_pin_in(capture_input_pin_in),
  .idle_in(idle_in), .capture_irq_out(capture_irq_out));

// ### bench/ecu_pulse_model.sv
// Purpose: Far-side source of single pulses on one capture pin
// Assumes: A new pulse is asked for only after the last one ended
// Notes: Width is in clock cycles, at least one
`timescale 1ns/10ps
module ecu_pulse_model (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic fire_in,
  input wire logic [3:0] width_in,
  output logic pin_out
);
  logic [3:0] left_reg;

  // Pin high for the asked width after a request, low otherwise
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      left_reg <= 4'h0;
      pin_out <= 1'b0;
    end else if (fire_in && left_reg == 4'h0) begin
      left_reg <= width_in;
      pin_out <= 1'b1;
    end else if (left_reg > 4'h1) begin
      left_reg <= left_reg - 4'h1;
    end else begin
      left_reg <= 4'h0;
      pin_out <= 1'b0;
    end
  end
endmodule

// ### bench/testbench.sv
// Purpose: Self-checking bench for the capture pair
// Assumes: Unit 0 is odd, unit 1 even, 0x10 apart
// Notes: Pulse widths and timer ticks are random with a fixed seed
`timescale 1ns/10ps
module testbench;
  import ecu_pkg::*;
  logic sys_clk_in = 0;
  logic reset_in = 1;
  logic psel_in = 0;
  logic penable_in = 0;
  logic pwrite_in = 0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [1:0] pin;
  logic [1:0] fire = 2'h0;
  logic [3:0] width = 4'h2;
  logic [4:0] timer_tick_in = 5'h00;
  logic [31:0] source_event_in = 32'h0;
  logic [31:0] source_on_in = 32'hFFFFFFFF;
  logic sleep_in = 0;
  logic idle_in = 0;
  logic [1:0] irq;
  logic [31:0] rd;
  logic err;
  logic [15:0] prev;
  logic [15:0] cfg[12] = '{16'h1C00, 16'h1C61, 16'h1C02, 16'h1C03,
    16'h1C23, 16'h1C43, 16'h1C63, 16'h1C04, 16'h1C05, 16'h1C06, 16'h1C07,
    16'h3C03};
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int n0 = 0;
  int n1 = 0;

  ecu_capture_pair ecu_capture_pair_inst (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .capture_input_pin_in(pin), .timer_tick_in(timer_tick_in),
    .source_event_in(source_event_in), .source_on_in(source_on_in),
    .sleep_in(sleep_in), .idle_in(idle_in), .capture_irq_out(irq));
  ecu_pulse_model pulse0_inst (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .fire_in(fire[0]), .width_in(width),
    .pin_out(pin[0]));
  ecu_pulse_model pulse1_inst (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .fire_in(fire[1]), .width_in(width),
    .pin_out(pin[1]));

  // Clock
  always #4 sys_clk_in = ~sys_clk_in;

  // Random timer ticks and run limit
  always @(posedge sys_clk_in) begin
    timer_tick_in <= 5'($urandom);
    cycles = cycles + 1;
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end

  // Interrupt tallies, sampled mid-cycle
  always @(negedge sys_clk_in) begin
    n0 = n0 + int'(irq[0] === 1'b1);
    n1 = n1 + int'(irq[1] !== 1'b0);
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; read data and error land in rd and err
  task automatic rw(input logic w, input logic [11:0] a,
    input logic [15:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {16'h0000, d};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // Only the run limit ends a wait for the slave
    do begin
      @(posedge sys_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // One pulse on both pins, then let the pins settle low
  task automatic pulse();
    @(posedge sys_clk_in);
    fire <= 2'h3;
    width <= 4'(2 + $urandom_range(4));
    @(posedge sys_clk_in);
    fire <= 2'h0;
    repeat (9) @(posedge sys_clk_in);
  endtask

  // Empty stale captures of one unit before it is set up
  task automatic drain(input logic [11:0] u);
    repeat (8) begin
      rw(1'b0, u, 16'h0000);
      if (rd[ECU_BNE_BIT] === 1'b0) break;
      rw(1'b0, u + ECU_OFS_BUF, 16'h0000);
    end
  endtask

  // Interrupts expected from 12 pulses, or 16 in the 16th-edge mode
  function automatic int exp_irq(input logic [15:0] c);
    int n;
    int caps;
    n = (c[2:0] == ECU_M_RISE16) ? 16 : 12;
    caps = 0;
    if (c[13]) return 0;
    case (c[2:0])
      ECU_M_EDGE: return 2 * n;
      ECU_M_WAKE: return n;
      ECU_M_FALL, ECU_M_RISE: caps = n;
      ECU_M_RISE4: caps = n / 4;
      ECU_M_RISE16: caps = n / 16;
      default: caps = 0;
    endcase
    return caps / (int'(c[6:5]) + 1);
  endfunction

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(63));
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rw(1'b0, ECU_OFS_CTL2, 16'h0000);
    check("ctl2 reset", rd, 32'(ECU_CTL2_RESET));
    rw(1'b0, 12'h00C, 16'h0000);
    check("unmapped", {31'h0, err}, 32'h1);
    rw(1'b1, ECU_OFS_CTL1, 16'hFFFF);
    rw(1'b0, ECU_OFS_CTL1, 16'h0000);
    check("ctl1 bits", rd, 32'(ECU_CTL1_WMASK));
    rw(1'b1, ECU_OFS_CTL2, 16'h0000);
    foreach (cfg[k]) begin
      rw(1'b1, ECU_OFS_CTL1, 16'h0000);
      rw(1'b1, ECU_OFS_CTL1, cfg[k]);
      sleep_in <= cfg[k][2:0] == ECU_M_WAKE;
      idle_in <= cfg[k][13];
      n0 = 0;
      repeat (cfg[k][2:0] == ECU_M_RISE16 ? 16 : 12) begin
        pulse();
        rw(1'b0, ECU_OFS_BUF, 16'h0000);
        rw(1'b0, ECU_OFS_BUF, 16'h0000);
      end
      check("irq count", n0, exp_irq(cfg[k]));
    end
    sleep_in <= 1'b0;
    idle_in <= 1'b0;
    rw(1'b1, ECU_OFS_CTL1, 16'h0000);
    drain(12'h000);
    rw(1'b1, ECU_OFS_CTL1, 16'h1C23);
    repeat (5) pulse();
    rw(1'b0, ECU_OFS_CTL1, 16'h0000);
    check("full flags", rd & 32'h18, 32'h18);
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, ECU_OFS_BUF, 16'h0000);
      if (i > 0) check("order", 32'(rd[15:0] > prev), 32'h1);
      prev = rd[15:0];
      rw(1'b0, ECU_OFS_CTL1, 16'h0000);
      check("flags", rd & 32'h18, i < 3 ? 32'h08 : 32'h00);
    end
    // Software trigger from source off, timer 1 time base
    rw(1'b1, ECU_OFS_CTL1, 16'h0000);
    rw(1'b1, ECU_OFS_CTL2, 16'h0080);
    rw(1'b1, ECU_OFS_CTL1, 16'h1003);
    // Not yet triggered: the edge is ignored, nothing lands in the FIFO
    pulse();
    rw(1'b0, ECU_OFS_CTL1, 16'h0000);
    check("held count", 32'(rd[ECU_BNE_BIT]), 32'h0);
    rw(1'b1, ECU_OFS_CTL2, 16'h00C0);
    rw(1'b0, ECU_OFS_CTL2, 16'h0000);
    check("running", 32'(rd[6]), 32'h1);
    repeat (40) @(posedge sys_clk_in);
    pulse();
    rw(1'b0, ECU_OFS_BUF, 16'h0000);
    check("running count", 32'(rd[15:0] != 16'h0), 32'h1);
    // Sync to source 5, which is not an analog one
    source_on_in <= 32'h0;
    rw(1'b1, ECU_OFS_CTL1, 16'h0000);
    drain(12'h000);
    rw(1'b1, ECU_OFS_CTL2, 16'h0005);
    rw(1'b1, ECU_OFS_CTL1, 16'h1C03);
    source_on_in <= 32'hFFFFFFFF;
    repeat (60) @(posedge sys_clk_in);
    source_event_in <= 32'h20;
    @(posedge sys_clk_in);
    source_event_in <= 32'h0;
    pulse();
    rw(1'b0, ECU_OFS_BUF, 16'h0000);
    check("sync restart", 32'(rd[15:0] < 16'h8), 32'h1);
    // Cascade: even unit first, same time base and source
    rw(1'b1, ECU_OFS_CTL1, 16'h0000);
    drain(12'h000);
    rw(1'b1, 12'h014, 16'h0100);
    rw(1'b1, ECU_OFS_CTL2, 16'h0100);
    rw(1'b1, 12'h010, 16'h1C00);
    rw(1'b1, ECU_OFS_CTL1, 16'h1C03);
    n0 = 0;
    for (int i = 0; i < 3; i++) begin
      pulse();
      rw(1'b0, ECU_OFS_CTL1, 16'h0000);
      check("pair ready", 32'(rd[ECU_BNE_BIT]), 32'h1);
      rw(1'b0, ECU_OFS_BUF, 16'h0000);
      rw(1'b0, 12'h018, 16'h0000);
      if (i > 0) check("high half", 32'(rd[15:0]), 32'(prev));
      prev = rd[15:0];
    end
    check("pair irq", n0, 32'h3);
    check("even irq", n1, 32'h0);
    complete_run();
  end
endmodule

// ### hdl/ecu_capture_pair.sv
// Purpose: Odd/even pair of edge capture units with FIFOs, APB slave
// Assumes: All inputs synchronous to sys_clk_in; event inputs are pulses
// Notes: Unit 0 is the odd unit (low half), unit 1 the even unit
//
// Overview of operation
// - Timestamp selected pin edges, interrupt per selection
// - Mode field picks edge, prescale, wake, off
// - Divider interrupts every 1-4 captures, except edge mode
// - Time base select picks timers or sysclk/2
// - Not-empty bit shows waiting values, read-only
// - Buffer read pops one value, bit clears once FIFO empty
// - Trigger-select one means trigger, zero sync
// - Running bit set by event or software; holds counter
// - Source code zero off, others pick events
// - Capture needs run bit (trigger) or source on (sync); time base unchecked
// - Cascade bit in both units forms 32 bits
// - Even unit runs synchronised to odd unit
// - Odd unit's divider, trigger, mode govern pair
// - Cascaded sync pair held until source enabled
// - Low half odd buffer, high half even
// - Each FIFO holds four values
// - Counter counts up, wraps, pushed on capture
// - Sync resets counter, trigger waits, software trigger
// - Odd wrap increments even counter
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module ecu_capture_pair (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [ecu_pkg::ECU_UNITS-1:0] capture_input_pin_in,
  input wire logic [4:0] timer_tick_in,
  input wire logic [31:0] source_event_in,
  input wire logic [31:0] source_on_in,
  input wire logic sleep_in,
  input wire logic idle_in,
  output logic [ecu_pkg::ECU_UNITS-1:0] capture_irq_out
);
  import ecu_pkg::*;

  // Per-unit register state
  logic [15:0] ctl1_reg [0:ECU_UNITS-1];
  logic [15:0] ctl2_reg [0:ECU_UNITS-1];
  logic [ECU_UNITS-1:0] run_reg;
  logic [ECU_UNITS-1:0] ovf_reg;
  logic [15:0] cnt_reg [0:ECU_UNITS-1];
  logic [15:0] head_w [0:ECU_UNITS-1];
  logic [ECU_UNITS-1:0] full_w;
  logic [ECU_UNITS-1:0] empty_w;

  // Per-unit derived control
  logic [ECU_UNITS-1:0] own_tick;
  logic [ECU_UNITS-1:0] own_go;
  logic [ECU_UNITS-1:0] own_clr;
  logic [ECU_UNITS-1:0] own_cap;
  logic [ECU_UNITS-1:0] own_irq;
  logic [ECU_UNITS-1:0] src_evt;
  logic [ECU_UNITS-1:0] cnt_inc;
  logic [ECU_UNITS-1:0] cnt_clr;
  logic [ECU_UNITS-1:0] cap_evt;
  logic [ECU_UNITS-1:0] push;
  logic [ECU_UNITS-1:0] pop;
  logic [ECU_UNITS-1:0] pin_reg;
  logic [ECU_UNITS-1:0] irq_reg;
  logic half_reg;
  logic cascade;

  // APB decode
  logic setup;
  logic access;
  logic hit;
  logic unit_sel;
  logic [1:0] reg_idx;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;

  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign unit_sel = paddr_in[4];
  assign reg_idx = paddr_in[3:2];
  assign hit = (paddr_in[11:5] == 7'h00) && (paddr_in[1:0] == 2'h0) &&
               (reg_idx != 2'h3);
  assign pready_out = 1'b1;
  assign pslverr_out = access && !hit;
  assign prdata_out = prdata_reg;

  // Both units must agree before the pair acts as one
  assign cascade = ctl2_reg[0][ECU_CAS_BIT] &&
                   ctl2_reg[1][ECU_CAS_BIT];

  // System clock divided by two as an enable pulse
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= !half_reg;
    end
  end

  // Pin history for edge detection
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= capture_input_pin_in;
    end
  end

  // Read data captured during setup, head word before the pop
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit) begin
      unique case (reg_idx)
        2'h0: begin
          rd_next[15:0] = ctl1_reg[unit_sel];
          rd_next[ECU_OVF_BIT] = ovf_reg[unit_sel];
          rd_next[ECU_BNE_BIT] = !empty_w[unit_sel];
        end
        2'h1: begin
          rd_next[15:0] = ctl2_reg[unit_sel];
          rd_next[ECU_RUN_BIT] = run_reg[unit_sel];
        end
        2'h2: begin
          rd_next[15:0] = head_w[unit_sel];
        end
        default: begin
          rd_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= rd_next;
    end
  end

  genvar u;
  generate
    for (u = 0; u < ECU_UNITS; u++) begin : g_unit
      logic [2:0] mode;
      logic [2:0] tsel;
      logic [1:0] interrupt_divider;
      logic [4:0] sel;
      logic trig;
      logic halt;
      logic src_on;
      logic rise;
      logic fall;
      logic wr_ctl1;
      logic wr_ctl2;
      logic [3:0] pre_reg;
      logic [1:0] ici_reg;
      logic pre_hit;

      assign mode = ctl1_reg[u][ECU_MODE_LSB +: 3];
      assign tsel = ctl1_reg[u][ECU_TSEL_LSB +: 3];
      assign interrupt_divider = ctl1_reg[u][ECU_ICI_LSB +: 2];
      assign halt = ctl1_reg[u][ECU_HALT_BIT] && idle_in;
      assign sel = ctl2_reg[u][ECU_SEL_LSB +: 5];
      assign trig = ctl2_reg[u][ECU_TRIG_BIT];
      assign wr_ctl1 = access && pwrite_in && hit &&
                       (unit_sel == 1'(u)) && (reg_idx == 2'h0);
      assign wr_ctl2 = access && pwrite_in && hit &&
                       (unit_sel == 1'(u)) && (reg_idx == 2'h1);
      assign rise = capture_input_pin_in[u] && !pin_reg[u];
      assign fall = !capture_input_pin_in[u] && pin_reg[u];

      // Source decode, code zero selects nothing
      assign src_evt[u] = (sel != ECU_SRC_OFF) &&
                          source_event_in[sel];
      assign src_on = (sel == ECU_SRC_OFF) || source_on_in[sel];

      // Time base enable pulse
      always_comb begin
        unique case (tsel)
          ECU_T_TMR3: own_tick[u] = timer_tick_in[2];
          ECU_T_TMR2: own_tick[u] = timer_tick_in[1];
          ECU_T_TMR4: own_tick[u] = timer_tick_in[3];
          ECU_T_TMR5: own_tick[u] = timer_tick_in[4];
          ECU_T_TMR1: own_tick[u] = timer_tick_in[0];
          ECU_T_SYS2: own_tick[u] = half_reg;
          default: own_tick[u] = 1'b0;
        endcase
      end

      // Counter may run: free, synchronised, or triggered
      always_comb begin
        if (trig) begin
          own_go[u] = run_reg[u];
        end else if (sel != ECU_SRC_OFF) begin
          own_go[u] = src_on;
        end else begin
          own_go[u] = 1'b1;
        end
      end
      assign own_clr[u] = !own_go[u] ||
                          (!trig && src_evt[u]);

      // Running flag, hardware set wins over a software clear
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          run_reg[u] <= 1'b0;
        end else if (trig && src_evt[u]) begin
          run_reg[u] <= 1'b1;
        end else if (wr_ctl2) begin
          run_reg[u] <= pwdata_in[ECU_RUN_BIT];
        end
      end

      // Control registers
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          ctl1_reg[u] <= ECU_CTL1_RESET;
          ctl2_reg[u] <= ECU_CTL2_RESET;
        end else begin
          if (wr_ctl1) begin
            ctl1_reg[u] <= pwdata_in[15:0] & ECU_CTL1_WMASK;
          end
          if (wr_ctl2) begin
            ctl2_reg[u] <= pwdata_in[15:0] & ECU_CTL2_WMASK;
          end
        end
      end

      // Edge prescaler for every 4th and 16th rising edge
      assign pre_hit = (mode == ECU_M_RISE4) ?
                       (pre_reg == ECU_PRE4_LAST) :
                       (pre_reg == ECU_PRE16_LAST);
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          pre_reg <= 4'h0;
        end else if (mode != ECU_M_RISE4 && mode != ECU_M_RISE16) begin
          pre_reg <= 4'h0;
        end else if (rise && own_go[u] && !halt) begin
          pre_reg <= pre_hit ? 4'h0 : pre_reg + 4'h1;
        end
      end

      // Own capture event from the mode field
      always_comb begin
        own_cap[u] = 1'b0;
        if (own_go[u] && !halt) begin
          unique case (mode)
            ECU_M_EDGE: own_cap[u] = rise || fall;
            ECU_M_FALL: own_cap[u] = fall;
            ECU_M_RISE: own_cap[u] = rise;
            ECU_M_RISE4: own_cap[u] = rise && pre_hit;
            ECU_M_RISE16: own_cap[u] = rise && pre_hit;
            default: own_cap[u] = 1'b0;
          endcase
        end
      end

      // Interrupt divider counts captures
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          ici_reg <= 2'h0;
        end else if (mode == ECU_M_OFF) begin
          ici_reg <= 2'h0;
        end else if (own_cap[u]) begin
          ici_reg <= (ici_reg >= interrupt_divider) ? 2'h0 : ici_reg + 2'h1;
        end
      end
      always_comb begin
        if (mode == ECU_M_WAKE) begin
          own_irq[u] = rise && sleep_in;
        end else if (mode == ECU_M_EDGE) begin
          own_irq[u] = own_cap[u];
        end else begin
          own_irq[u] = own_cap[u] && (ici_reg >= interrupt_divider);
        end
      end

      // Overflow flag, a lost capture wins over the clear
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          ovf_reg[u] <= 1'b0;
        end else if (cap_evt[u] && full_w[u] && !pop[u]) begin
          ovf_reg[u] <= 1'b1;
        end else if (pop[u] || mode == ECU_M_OFF) begin
          ovf_reg[u] <= 1'b0;
        end
      end

      // Free-running counter, cleared while held
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          cnt_reg[u] <= 16'h0000;
        end else if (cnt_clr[u]) begin
          cnt_reg[u] <= 16'h0000;
        end else if (cnt_inc[u]) begin
          cnt_reg[u] <= cnt_reg[u] + 16'h0001;
        end
      end

      // A read of the buffer pops one value
      assign pop[u] = access && !pwrite_in && hit && !empty_w[u] &&
                      (unit_sel == 1'(u)) && (reg_idx == 2'h2);
      assign push[u] = cap_evt[u] && (!full_w[u] || pop[u]);

      ecu_fifo u_fifo (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .push_in(push[u]),
        .pop_in(pop[u]),
        .data_in(cnt_reg[u]),
        .head_out(head_w[u]),
        .full_out(full_w[u]),
        .empty_out(empty_w[u])
      );
    end
  endgenerate

  // Odd unit always runs on its own settings
  assign cnt_clr[0] = own_clr[0];
  assign cnt_inc[0] = own_tick[0] && !(ctl1_reg[0][ECU_HALT_BIT] && idle_in);
  assign cap_evt[0] = own_cap[0];

  // Even unit follows the odd unit when cascaded
  assign cnt_clr[1] = cascade ? own_clr[0] : own_clr[1];
  assign cnt_inc[1] = cascade ?
                      (cnt_inc[0] && cnt_reg[0] == ECU_CNT_TOP) :
                      (own_tick[1] &&
                       !(ctl1_reg[1][ECU_HALT_BIT] && idle_in));
  assign cap_evt[1] = cascade ? own_cap[0] : own_cap[1];

  // Interrupt pulses, pair interrupt from the odd unit
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_reg <= '0;
    end else begin
      irq_reg[0] <= own_irq[0];
      irq_reg[1] <= cascade ? 1'b0 : own_irq[1];
    end
  end
  assign capture_irq_out = irq_reg;
endmodule

// ### hdl/ecu_fifo.sv
// Purpose: Four-entry capture value FIFO
// Assumes: Caller blocks pop while empty, and push while full unless it pops in the same cycle
// Notes: Head word is visible without a pop
`timescale 1ns/10ps
module ecu_fifo (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [ecu_pkg::ECU_WIDTH-1:0] data_in,
  output logic [ecu_pkg::ECU_WIDTH-1:0] head_out,
  output logic full_out,
  output logic empty_out
);
  import ecu_pkg::*;

  logic [ECU_WIDTH-1:0] mem [0:ECU_DEPTH-1];
  logic [1:0] wptr_reg;
  logic [1:0] rptr_reg;
  logic [2:0] count_reg;

  // Storage write
  always_ff @(posedge sys_clk_in) begin
    if (push_in) begin
      mem[wptr_reg] <= data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wptr_reg <= 2'h0;
      rptr_reg <= 2'h0;
      count_reg <= 3'h0;
    end else begin
      if (push_in) begin
        wptr_reg <= wptr_reg + 2'h1;
      end
      if (pop_in) begin
        rptr_reg <= rptr_reg + 2'h1;
      end
      if (push_in && !pop_in) begin
        count_reg <= count_reg + 3'h1;
      end else if (pop_in && !push_in) begin
        count_reg <= count_reg - 3'h1;
      end
    end
  end

  assign head_out = mem[rptr_reg];
  assign full_out = (count_reg == 3'(ECU_DEPTH));
  assign empty_out = (count_reg == 3'h0);
endmodule

// ### hdl/ecu_pkg.sv
// Purpose: Shared constants for the edge capture pair
// Assumes: APB with 32-bit data, registers in the low 16 bits
// Notes: Two units, odd (index 0) and even (index 1)
package ecu_pkg;
  // Register byte offsets within one unit, units 0x10 apart
  localparam logic [11:0] ECU_OFS_CTL1 = 12'h000;
  localparam logic [11:0] ECU_OFS_CTL2 = 12'h004;
  localparam logic [11:0] ECU_OFS_BUF = 12'h008;
  localparam logic [11:0] ECU_UNIT_STRIDE = 12'h010;
  localparam int ECU_UNITS = 2;
  localparam int ECU_DEPTH = 4;
  localparam int ECU_WIDTH = 16;

  // Primary control fields
  localparam int ECU_HALT_BIT = 13;
  localparam int ECU_TSEL_LSB = 10;
  localparam int ECU_ICI_LSB = 5;
  localparam int ECU_OVF_BIT = 4;
  localparam int ECU_BNE_BIT = 3;
  localparam int ECU_MODE_LSB = 0;
  localparam logic [15:0] ECU_CTL1_WMASK = 16'h3C67;
  localparam logic [15:0] ECU_CTL1_RESET = 16'h0000;

  // Secondary control fields
  localparam int ECU_CAS_BIT = 8;
  localparam int ECU_TRIG_BIT = 7;
  localparam int ECU_RUN_BIT = 6;
  localparam int ECU_SEL_LSB = 0;
  localparam logic [15:0] ECU_CTL2_WMASK = 16'h019F;
  localparam logic [15:0] ECU_CTL2_RESET = 16'h000D;

  // Capture modes
  localparam logic [2:0] ECU_M_OFF = 3'h0;
  localparam logic [2:0] ECU_M_EDGE = 3'h1;
  localparam logic [2:0] ECU_M_FALL = 3'h2;
  localparam logic [2:0] ECU_M_RISE = 3'h3;
  localparam logic [2:0] ECU_M_RISE4 = 3'h4;
  localparam logic [2:0] ECU_M_RISE16 = 3'h5;
  localparam logic [2:0] ECU_M_DIS = 3'h6;
  localparam logic [2:0] ECU_M_WAKE = 3'h7;

  // Time base codes
  localparam logic [2:0] ECU_T_TMR3 = 3'h0;
  localparam logic [2:0] ECU_T_TMR2 = 3'h1;
  localparam logic [2:0] ECU_T_TMR4 = 3'h2;
  localparam logic [2:0] ECU_T_TMR5 = 3'h3;
  localparam logic [2:0] ECU_T_TMR1 = 3'h4;
  localparam logic [2:0] ECU_T_SYS2 = 3'h7;

  // Prescale terminal counts and source code for off
  localparam logic [3:0] ECU_PRE4_LAST = 4'h3;
  localparam logic [3:0] ECU_PRE16_LAST = 4'hF;
  localparam logic [4:0] ECU_SRC_OFF = 5'h00;
  localparam logic [15:0] ECU_CNT_TOP = 16'hFFFF;
endpackage
